// ### hdl/mss_consts.vh
// Constants of the multi-segment position sequencer.
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH
`define MSS_ADDR_CTRL 8'h00
`define MSS_ADDR_MODE 8'h04
`define MSS_ADDR_START 8'h08
`define MSS_ADDR_END 8'h0C
`define MSS_ADDR_STATUS 8'h10
`define MSS_MODE_SINGLE 2'h0
`define MSS_MODE_CYCLE 2'h1
`define MSS_MODE_INPUT 2'h2
`define MSS_SRC_MULTISEG 2'h1
`define MSS_SEG_DEFAULT 5'h01
`define MSS_SEG_MAX 5'h10
`define MSS_CTRL_POSMODE_BIT 0
`define MSS_CTRL_RESUME_BIT 1
`define MSS_CTRL_SRC_LSB 4
`define MSS_ST_RUN_BIT 0
`define MSS_ST_PAUSE_BIT 1
`define MSS_ST_DONE_BIT 2
`define MSS_ST_SEG_LSB 8
`define MSS_RESP_OKAY 2'h0
`define MSS_RESP_SLVERR 2'h2
`endif

// ### hdl/mss_seg_next.v
// Next-segment calculation for automatic stepping.
`timescale 1ns/1ps
module mss_seg_next (
    input wire [4:0] cur_seg,
    input wire [4:0] start_seg,
    input wire [4:0] end_seg,
    output reg [4:0] next_seg,
    output reg last_seg
);
    always @* begin
        last_seg = (cur_seg >= end_seg);
        if (last_seg) begin
            next_seg = start_seg;
        end else begin
            next_seg = cur_seg + 5'h01;
        end
    end
endmodule

// ### hdl/mss_sequencer.v
// Multi-segment position sequencer with AXI4-Lite registers.
// Behaviour
// - Active only in internal multi-segment position mode.
// - Mode 0 steps once through, then stops.
// - Mode 1 repeats the segment sequence forever.
// - Mode 2 follows select inputs on change.
// - Segments run only while enable is valid.
// - Start segment 1..16, default 1.
// - End segment 1..16, default 1.
// - Automatic mode steps by one start to end.
// - Four select inputs driven by external controller.
// - Segment equals select binary value plus one.
// - Select bit is one when input valid.
// - Enable falling edge pauses, abandoning current segment.
// - Resume continues next segment or restarts.
`timescale 1ns/1ps
`include "mss_consts.vh"
module mss_sequencer (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire multiseg_enable_input,
    input wire segment_select_bit0,
    input wire segment_select_bit1,
    input wire segment_select_bit2,
    input wire segment_select_bit3,
    input wire segment_done,
    output reg segment_start,
    output reg [4:0] active_segment,
    output reg segment_abort,
    output reg seq_running
);
    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_RUN = 4'b0010;
    localparam ST_PAUSE = 4'b0100;
    localparam ST_DONE = 4'b1000;

    reg [3:0] state_q;
    reg [1:0] mode_q;
    reg [4:0] start_q;
    reg [4:0] end_q;
    reg posmode_q;
    reg resume_q;
    reg [1:0] src_q;
    reg en_prev_q;
    reg [3:0] sel_prev_q;
    reg [4:0] resume_seg_q;
    reg aw_got_q;
    reg w_got_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    wire [4:0] next_seg;
    wire last_seg;
    wire enabled;
    wire [3:0] sel_bits;
    wire [4:0] sel_seg;
    wire stopped;
    wire do_write;
    wire [4:0] wseg;
    wire seg_ok;

    // ----------------------------------------------------------------
    // Segment selection
    // ----------------------------------------------------------------
    // Inputs are already at their valid-level meaning here; polarity is handled upstream.
    assign sel_bits = {segment_select_bit3, segment_select_bit2,
                       segment_select_bit1, segment_select_bit0};
    assign sel_seg = {1'b0, sel_bits} + 5'h01;
    assign enabled = posmode_q && (src_q == `MSS_SRC_MULTISEG) &&
                     multiseg_enable_input;
    assign stopped = (state_q != ST_RUN);

    mss_seg_next u_next (
        .cur_seg(active_segment),
        .start_seg(start_q),
        .end_seg(end_q),
        .next_seg(next_seg),
        .last_seg(last_seg)
    );

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
    assign wseg = wdata_q[4:0];
    assign seg_ok = (wseg >= 5'h01) && (wseg <= `MSS_SEG_MAX) && (wdata_q[31:5] == 27'h0);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MSS_RESP_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            mode_q <= `MSS_MODE_SINGLE;
            start_q <= `MSS_SEG_DEFAULT;
            end_q <= `MSS_SEG_DEFAULT;
            posmode_q <= 1'b0;
            resume_q <= 1'b0;
            src_q <= 2'h0;
        end else begin
            s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `MSS_RESP_OKAY;
                case (awaddr_q)
                    `MSS_ADDR_CTRL: begin
                        posmode_q <= wdata_q[`MSS_CTRL_POSMODE_BIT];
                        resume_q <= wdata_q[`MSS_CTRL_RESUME_BIT];
                        src_q <= wdata_q[`MSS_CTRL_SRC_LSB+1:`MSS_CTRL_SRC_LSB];
                    end
                    `MSS_ADDR_MODE: begin
                        // A write while running is refused so a pass cannot change shape.
                        if (stopped && wdata_q[1:0] <= `MSS_MODE_INPUT) begin
                            mode_q <= wdata_q[1:0];
                        end else begin
                            s_axi_bresp <= `MSS_RESP_SLVERR;
                        end
                    end
                    `MSS_ADDR_START: begin
                        if (stopped && seg_ok) begin
                            start_q <= wseg;
                        end else begin
                            s_axi_bresp <= `MSS_RESP_SLVERR;
                        end
                    end
                    `MSS_ADDR_END: begin
                        if (stopped && seg_ok) begin
                            end_q <= wseg;
                        end else begin
                            s_axi_bresp <= `MSS_RESP_SLVERR;
                        end
                    end
                    default: begin
                        s_axi_bresp <= `MSS_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MSS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `MSS_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr)
                    `MSS_ADDR_CTRL: begin
                        s_axi_rdata <= {26'h0, src_q, 2'h0, resume_q, posmode_q};
                    end
                    `MSS_ADDR_MODE: begin
                        s_axi_rdata <= {30'h0, mode_q};
                    end
                    `MSS_ADDR_START: begin
                        s_axi_rdata <= {27'h0, start_q};
                    end
                    `MSS_ADDR_END: begin
                        s_axi_rdata <= {27'h0, end_q};
                    end
                    `MSS_ADDR_STATUS: begin
                        s_axi_rdata <= {19'h0, active_segment, 5'h0,
                                        state_q == ST_DONE, state_q == ST_PAUSE,
                                        state_q == ST_RUN};
                    end
                    default: begin
                        s_axi_rresp <= `MSS_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            active_segment <= `MSS_SEG_DEFAULT;
            resume_seg_q <= `MSS_SEG_DEFAULT;
            segment_start <= 1'b0;
            segment_abort <= 1'b0;
            seq_running <= 1'b0;
            en_prev_q <= 1'b0;
            sel_prev_q <= 4'h0;
        end else begin
            segment_start <= 1'b0;
            segment_abort <= 1'b0;
            en_prev_q <= enabled;
            sel_prev_q <= sel_bits;
            case (state_q)
                ST_IDLE: begin
                    if (enabled) begin
                        state_q <= ST_RUN;
                        seq_running <= 1'b1;
                        segment_start <= 1'b1;
                        if (mode_q == `MSS_MODE_INPUT) begin
                            active_segment <= sel_seg;
                        end else begin
                            active_segment <= start_q;
                        end
                    end
                end
                ST_RUN: begin
                    if (en_prev_q && !enabled) begin
                        // Pause drops the rest of the segment at once.
                        state_q <= ST_PAUSE;
                        seq_running <= 1'b0;
                        segment_abort <= 1'b1;
                        resume_seg_q <= resume_q ? start_q : next_seg;
                    end else if (mode_q == `MSS_MODE_INPUT) begin
                        if (sel_bits != sel_prev_q) begin
                            active_segment <= sel_seg;
                            segment_start <= 1'b1;
                        end
                    end else if (segment_done) begin
                        if (last_seg && mode_q == `MSS_MODE_SINGLE) begin
                            state_q <= ST_DONE;
                            seq_running <= 1'b0;
                        end else begin
                            active_segment <= next_seg;
                            segment_start <= 1'b1;
                        end
                    end
                end
                ST_PAUSE: begin
                    if (enabled) begin
                        state_q <= ST_RUN;
                        seq_running <= 1'b1;
                        segment_start <= 1'b1;
                        if (mode_q == `MSS_MODE_INPUT) begin
                            active_segment <= sel_seg;
                        end else begin
                            active_segment <= resume_seg_q;
                        end
                    end
                end
                ST_DONE: begin
                    // A new pass needs the enable to be withdrawn and given again.
                    if (!enabled) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ### tb/mss_sequencer_sva.sv
// Assertion checker for the multi-segment position sequencer.
`timescale 1ns/1ps
module mss_sequencer_sva (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic multiseg_enable_input,
    input logic segment_start,
    input logic [4:0] active_segment,
    input logic segment_abort,
    input logic seq_running
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_seg_range;
        seq_running |-> active_segment >= 5'h01 && active_segment <= 5'h10;
    endproperty
    a_seg_range: assert property (p_seg_range) else $error("segment out of range");
    property p_start_run;
        segment_start |-> seq_running;
    endproperty
    a_start_run: assert property (p_start_run) else $error("start outside run");
    property p_run_en;
        !multiseg_enable_input [*4] |-> !seq_running;
    endproperty
    a_run_en: assert property (p_run_en) else $error("running without enable");
    property p_no_start_off;
        !multiseg_enable_input [*3] |-> !segment_start;
    endproperty
    a_no_start_off: assert property (p_no_start_off) else $error("start while disabled");
    property p_abort;
        seq_running && $fell(multiseg_enable_input) |-> ##[1:3] segment_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on pause");
    property p_abort_stop;
        segment_abort |-> !seq_running;
    endproperty
    a_abort_stop: assert property (p_abort_stop) else $error("running after abort");
    property p_abort_once;
        segment_abort |=> !segment_abort;
    endproperty
    a_abort_once: assert property (p_abort_once) else $error("abort longer than a pulse");
    property p_ar_r;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_ar_r: assert property (p_ar_r) else $error("read data late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    c_abort: cover property (segment_abort);
    c_seg16: cover property (segment_start && active_segment == 5'h10);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind mss_sequencer mss_sequencer_sva i_mss_sequencer_sva (.aclk, .aresetn, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .multiseg_enable_input,
    .segment_start, .active_segment, .segment_abort, .seq_running);

// ### tb/mss_host_model.sv
// Host controller and motion engine stand-in driving the sequencer inputs.
`timescale 1ns/1ps
module mss_host_model (
    input logic aclk,
    input logic en_req,
    input logic [3:0] sel_req,
    input logic hold_done,
    input logic segment_start,
    output logic multiseg_enable_input,
    output logic [3:0] sel_bits,
    output logic segment_done
);
    // Segment length is random so that stepping is seen fast and slow.
    int wait_q = 0;
    initial begin
        multiseg_enable_input = 1'b0;
        sel_bits = 4'h0;
        segment_done = 1'b0;
    end
    always @(posedge aclk) begin
        multiseg_enable_input <= en_req;
        sel_bits <= sel_req;
        segment_done <= 1'b0;
        if (segment_start) begin
            wait_q <= $urandom_range(8, 3);
        end else if (wait_q > 1) begin
            wait_q <= wait_q - 1;
        end else if (wait_q == 1) begin
            wait_q <= 0;
            segment_done <= !hold_done;
        end
    end
endmodule

// ### tb/multi_segment_position_sequencer_tb_top.sv
// Self-checking testbench for the multi-segment position sequencer.
`timescale 1ns/1ps
`include "mss_consts.vh"
module multi_segment_position_sequencer_tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, seg_start, seg_abort, running, en, done;
    logic [1:0] bresp, rresp;
    logic [4:0] act_seg;
    logic [3:0] sel, v, sel_req = 0;
    logic en_req = 0, hold = 1;
    logic [1:0] qb[$];
    logic [33:0] qr[$];
    logic [4:0] qs[$];
    int fails = 0, samples_checked = 0, cycles = 0, aborts = 0;
    mss_sequencer i_mss_sequencer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .multiseg_enable_input(en), .segment_select_bit0(sel[0]), .segment_select_bit1(sel[1]),
        .segment_select_bit2(sel[2]), .segment_select_bit3(sel[3]), .segment_done(done),
        .segment_start(seg_start), .active_segment(act_seg), .segment_abort(seg_abort),
        .seq_running(running));
    mss_host_model i_mss_host_model (.aclk(aclk), .en_req(en_req), .sel_req(sel_req),
        .hold_done(hold), .segment_start(seg_start), .multiseg_enable_input(en),
        .sel_bits(sel), .segment_done(done));
    initial forever #12.5 aclk = ~aclk;
    // ----
    // Checking
    // ----
    task check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (bvalid && bready) check("bresp", 34'(bresp), 34'(qb.pop_front()));
        if (rvalid && rready) check("rdata", {rresp, rdata}, qr.pop_front());
        if (seg_abort) aborts++;
        // An unannounced start is held against segment 0, which the design never shows.
        if (seg_start) check("segment", 34'(act_seg),
                             (qs.size() != 0) ? 34'(qs.pop_front()) : 34'h0);
        if (cycles > 5000) begin
            fails++;
            give_verdict();
        end
    end
    // ----
    // Bus cycles
    // ----
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 0);
        logic aw_open;
        logic w_open;
        @(posedge aclk);
        qb.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Local flags, since the valids themselves only change after this time step.
        aw_open = 1'b1;
        w_open = 1'b1;
        while (aw_open || w_open) begin
            @(posedge aclk);
            if (aw_open && awready) begin
                awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (w_open && wready) begin
                wvalid <= 1'b0;
                w_open = 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 0);
        @(posedge aclk);
        qr.push_back({er, ed});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic pause_resume(input logic [4:0] seg, input int n);
        en_req <= 1'b0;
        repeat (10) @(posedge aclk);
        check("aborts", 34'(aborts), 34'(n));
        rd(`MSS_ADDR_STATUS, 32'h0000_0f02);
        qs.push_back(seg);
        en_req <= 1'b1;
        repeat (10) @(posedge aclk);
    endtask
    // ----
    // Scenarios
    // ----
    initial begin
        void'($urandom(32'h950d_fb05));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`MSS_ADDR_STATUS, 32'h0000_0100);
        rd(`MSS_ADDR_START, 32'h0000_0001);
        rd(`MSS_ADDR_END, 32'h0000_0001);
        rd(`MSS_ADDR_MODE, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000, `MSS_RESP_SLVERR);
        wr(`MSS_ADDR_MODE, 32'h0000_0003, `MSS_RESP_SLVERR);
        wr(`MSS_ADDR_START, 32'h0000_0000, `MSS_RESP_SLVERR);
        wr(`MSS_ADDR_END, 32'h0000_0011, `MSS_RESP_SLVERR);
        wr(`MSS_ADDR_END, 32'h0000_0005);
        wr(`MSS_ADDR_START, 32'h0000_0003);
        en_req <= 1'b1;
        hold <= 1'b0;
        repeat (10) @(posedge aclk);
        qs = {5'h03, 5'h04, 5'h05};
        wr(`MSS_ADDR_CTRL, 32'h0000_0011);
        while (qs.size() != 0) @(posedge aclk);
        repeat (20) @(posedge aclk);
        check("running", 34'(running), 34'h0);
        rd(`MSS_ADDR_STATUS, 32'h0000_0504);
        en_req <= 1'b0;
        hold <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(`MSS_ADDR_MODE, 32'h0000_0002);
        for (int i = 0; i < 8; i++) begin
            v = (i < 2) ? 4'(i * 15) : 4'(v + $urandom_range(15, 1));
            sel_req <= v;
            qs.push_back(5'(v) + 5'h01);
            en_req <= 1'b1;
            repeat (8) @(posedge aclk);
        end
        aresetn <= 1'b0;
        en_req <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wr(`MSS_ADDR_START, 32'h0000_000f);
        wr(`MSS_ADDR_END, 32'h0000_0010);
        wr(`MSS_ADDR_MODE, 32'h0000_0001);
        hold <= 1'b0;
        en_req <= 1'b1;
        qs = {5'h0f, 5'h10, 5'h0f};
        wr(`MSS_ADDR_CTRL, 32'h0000_0011);
        while (qs.size() != 0) @(posedge aclk);
        hold <= 1'b1;
        wr(`MSS_ADDR_MODE, 32'h0000_0000, `MSS_RESP_SLVERR);
        rd(`MSS_ADDR_MODE, 32'h0000_0001);
        wr(`MSS_ADDR_CTRL, 32'h0000_0013);
        pause_resume(5'h0f, 1);
        wr(`MSS_ADDR_CTRL, 32'h0000_0011);
        pause_resume(5'h10, 2);
        give_verdict();
    end
endmodule
